// ==== hdl/cmb_defs.svh ====
// constants of the message-buffer identifier block: offsets, fields, counts
// assumes inclusion by bare name from the block file and the bench
`ifndef CMB_DEFS_SVH
`define CMB_DEFS_SVH

// ------------------------------------------------------------------
// register byte addresses on the apb side
// ------------------------------------------------------------------
`define CMB_ADDR_W 6
`define CMB_OFS_TXID0 6'h00
`define CMB_OFS_TXID1 6'h04
`define CMB_OFS_TXID2 6'h08
`define CMB_OFS_TXID3 6'h0C
`define CMB_OFS_RXID0 6'h10
`define CMB_OFS_RXID1 6'h14
`define CMB_OFS_RXID2 6'h18
`define CMB_OFS_RXID3 6'h1C
`define CMB_OFS_CTRL 6'h20

// ------------------------------------------------------------------
// control / status fields
// ------------------------------------------------------------------
`define CMB_CTL_GO 0
`define CMB_CTL_TXE 0
`define CMB_CTL_RXF 1
`define CMB_CTL_ARBL 2
`define CMB_CTL_TXSEL 4

// ------------------------------------------------------------------
// identifier byte 1 fields and arbitration-field lengths
// ------------------------------------------------------------------
`define CMB_B1_SRR 4
`define CMB_B1_IDE 3
`define CMB_B1_STD_RTR 4
`define CMB_STD_BITS 6'h0D
`define CMB_EXT_BITS 6'h20

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define CMB_CLK_MHZ 250
`define CMB_BIT_NS 1000
`define CMB_BIT_CYC ((`CMB_BIT_NS * `CMB_CLK_MHZ) / 1000)

`endif

// ==== hdl/cmb_pkg.sv ====
// types shared by the message-buffer identifier block
// assumes cmb_defs.svh is on the include path
package cmb_pkg;

  // transmit sequencer states, one-hot
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } cmb_tx_state_type;

endpackage : cmb_pkg

// ==== hdl/cmb_idmap.sv ====
// identifier bytes of one transmit and one receive message buffer
// behind an apb slave, with the arbitration-field shifter to the bus.
// assumes can_rx is already synchronous to pclk and rx_frame marks the
// arbitration field of a frame being received, set by the bit engine.
//
// Contract
// - extended identifier has 29 bits, sent most significant bit first
// - smallest identifier value wins arbitration, both formats
// - extended byte 1: id20..18 at bits 7..5, id17..15 at bits 2..0
// - extended byte 2 holds id14..7 in all eight bits
// - extended byte 3: id6..0 at bits 7..1, remote bit at bit 0
// - receive buffer stores substitute-remote bit as seen on the bus
// - byte 1 bit 3: 0 standard 11-bit, 1 extended 29-bit; selects sent format
// - receive buffer records the received frame's format bit
// - remote bit holds received status, or is the transmitted remote bit
// - standard identifier has 11 bits, sent most significant bit first
// - standard: byte 0 holds id10..3, byte 1 bits 7..5 hold id2..0
// - standard byte 1: remote bit at bit 4, format bit at bit 3
// - bits unused by standard mapping read undefined
// - extended byte 0 holds id28..21 in all eight bits
// - identifier bytes are not reset; contents undefined after reset
//
// Our own choices: the placing of the registers and register access over APB.
`include "cmb_defs.svh"

module cmb_idmap #(
  parameter int BIT_DIV = `CMB_BIT_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // can side
  input wire logic can_rx,
  input wire logic rx_frame,
  output logic can_tx
);

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  // buffers are ram-like: no reset, contents undefined until written
  logic [7:0] txid_q [4];
  logic [7:0] rxid_q [4];
  logic transmit_buffer_empty_flag_q;
  logic receive_buffer_full_flag_q;
  logic transmit_buffer_select_q;
  logic arb_lost_q;
  cmb_pkg::cmb_tx_state_type tx_state_q;
  logic [31:0] tx_sh_q;
  logic [5:0] tx_cnt_q;
  logic [5:0] tx_len_q;
  logic can_tx_q;
  logic [31:0] rx_sh_q;
  logic [5:0] rx_cnt_q;
  logic rx_std_q;
  logic [15:0] div_q;
  logic tick_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  logic [`CMB_ADDR_W-1:0] addr;
  logic acc;
  logic wr_acc;
  logic mapped;
  logic tx_wr_ok;
  logic go_req;
  logic rxf_clr;
  logic arbl_clr;
  logic rx_done;
  logic tx_start;
  logic tx_lost;
  logic tx_end;

  assign addr = paddr[`CMB_ADDR_W-1:0];
  // answer on the second access cycle, registered pready
  assign acc = psel & penable & ~pready_q;
  // writes land at the completion edge, the one at which the master sees pready
  assign wr_acc = psel & penable & pready_q & pwrite & mapped;
  assign mapped = (paddr[31:`CMB_ADDR_W] == '0) && (addr[1:0] == 2'h0)
                  && (addr <= `CMB_OFS_CTRL);
  // transmit-byte writes and go land only while the buffer is empty and selected
  assign tx_wr_ok = transmit_buffer_empty_flag_q & transmit_buffer_select_q;
  assign go_req = wr_acc && (addr == `CMB_OFS_CTRL) && pwdata[`CMB_CTL_GO];
  assign rxf_clr = wr_acc && (addr == `CMB_OFS_CTRL) && pwdata[`CMB_CTL_RXF];
  assign arbl_clr = wr_acc && (addr == `CMB_OFS_CTRL) && pwdata[`CMB_CTL_ARBL];
  assign tx_start = go_req && tx_wr_ok && (tx_state_q == cmb_pkg::TX_IDLE);

  // ------------------------------------------------------------------
  // apb handshake and read data
  // ------------------------------------------------------------------
  // one wait state; unmapped addresses answer with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc;
      pslverr_q <= acc & ~mapped;
      prdata_q <= 32'h0000_0000;
      if (acc && !pwrite && mapped) begin
        unique case (addr)
          `CMB_OFS_TXID0: prdata_q <= {24'h000000, txid_q[0]};
          `CMB_OFS_TXID1: prdata_q <= {24'h000000, txid_q[1]};
          `CMB_OFS_TXID2: prdata_q <= {24'h000000, txid_q[2]};
          `CMB_OFS_TXID3: prdata_q <= {24'h000000, txid_q[3]};
          `CMB_OFS_RXID0: prdata_q <= {24'h000000, rxid_q[0]};
          // standard frames leave bits 2..0 stale, hence undefined
          `CMB_OFS_RXID1: prdata_q <= {24'h000000, rxid_q[1]};
          `CMB_OFS_RXID2: prdata_q <= {24'h000000, rxid_q[2]};
          `CMB_OFS_RXID3: prdata_q <= {24'h000000, rxid_q[3]};
          default: begin
            prdata_q[`CMB_CTL_TXE] <= transmit_buffer_empty_flag_q;
            prdata_q[`CMB_CTL_RXF] <= receive_buffer_full_flag_q;
            prdata_q[`CMB_CTL_ARBL] <= arb_lost_q;
            prdata_q[`CMB_CTL_TXSEL] <= transmit_buffer_select_q;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // transmit identifier bytes
  // ------------------------------------------------------------------
  // software owns the layout; srr must be written 1 for extended
  always_ff @(posedge pclk) begin
    if (wr_acc && tx_wr_ok && (addr < `CMB_OFS_RXID0)) begin
      txid_q[addr[3:2]] <= pwdata[7:0];
    end
  end

  // ------------------------------------------------------------------
  // control and status flags
  // ------------------------------------------------------------------
  // buffer select is plain read/write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_buffer_select_q <= 1'b0;
    end else if (wr_acc && (addr == `CMB_OFS_CTRL)) begin
      transmit_buffer_select_q <= pwdata[`CMB_CTL_TXSEL];
    end
  end

  // empty flag drops on go and returns at end of field or loss
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_buffer_empty_flag_q <= 1'b1;
    end else if (tx_end || tx_lost) begin
      transmit_buffer_empty_flag_q <= 1'b1;
    end else if (tx_start) begin
      transmit_buffer_empty_flag_q <= 1'b0;
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_buffer_full_flag_q <= 1'b0;
      arb_lost_q <= 1'b0;
    end else begin
      if (rx_done) begin
        receive_buffer_full_flag_q <= 1'b1;
      end else if (rxf_clr) begin
        receive_buffer_full_flag_q <= 1'b0;
      end
      if (tx_lost) begin
        arb_lost_q <= 1'b1;
      end else if (arbl_clr) begin
        arb_lost_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // bit-rate enable
  // ------------------------------------------------------------------
  // one-cycle tick per can bit time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (div_q == 16'(BIT_DIV - 1)) begin
      div_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // transmit arbitration-field shifter
  // ------------------------------------------------------------------
  // the four bytes in order already form the extended field
  // id28..18, srr, ide, id17..0, rtr; standard uses the top 13 bits.
  // a recessive bit read back dominant means a smaller id is on the bus
  assign tx_lost = (tx_state_q == cmb_pkg::TX_SHIFT) && tick_q
                   && (tx_cnt_q != 6'h00) && can_tx_q && !can_rx;
  assign tx_end = (tx_state_q == cmb_pkg::TX_SHIFT) && tick_q && !tx_lost
                  && (tx_cnt_q == tx_len_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_q <= cmb_pkg::TX_IDLE;
      tx_sh_q <= 32'h0000_0000;
      tx_cnt_q <= 6'h00;
      tx_len_q <= `CMB_EXT_BITS;
      can_tx_q <= 1'b1;
    end else begin
      unique case (tx_state_q)
        cmb_pkg::TX_IDLE: begin
          can_tx_q <= 1'b1;
          if (tx_start) begin
            tx_sh_q <= {txid_q[0], txid_q[1], txid_q[2], txid_q[3]};
            tx_cnt_q <= 6'h00;
            // format bit picks 13 or 32 field bits
            tx_len_q <= txid_q[1][`CMB_B1_IDE] ? `CMB_EXT_BITS : `CMB_STD_BITS;
            tx_state_q <= cmb_pkg::TX_SHIFT;
          end
        end
        cmb_pkg::TX_SHIFT: begin
          if (tx_lost || tx_end) begin
            can_tx_q <= 1'b1;
            tx_state_q <= cmb_pkg::TX_IDLE;
          end else if (tick_q) begin
            // msb first: id28 or id10 leads
            can_tx_q <= tx_sh_q[31];
            tx_sh_q <= {tx_sh_q[30:0], 1'b0};
            tx_cnt_q <= tx_cnt_q + 6'h01;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // receive arbitration-field collector
  // ------------------------------------------------------------------
  // the 13th bit is the format bit; 0 ends a standard field there
  assign rx_done = rx_frame && tick_q
                   && (((rx_cnt_q == (`CMB_STD_BITS - 6'h01)) && !can_rx)
                       || (rx_cnt_q == (`CMB_EXT_BITS - 6'h01)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sh_q <= 32'h0000_0000;
      rx_cnt_q <= 6'h00;
      rx_std_q <= 1'b0;
    end else if (!rx_frame || rx_done) begin
      // frame signal ends the field, so a cut frame never stores
      rx_cnt_q <= 6'h00;
      if (rx_done) begin
        rx_sh_q <= {rx_sh_q[30:0], can_rx};
        rx_std_q <= (rx_cnt_q == (`CMB_STD_BITS - 6'h01));
      end
    end else if (tick_q) begin
      rx_sh_q <= {rx_sh_q[30:0], can_rx};
      rx_cnt_q <= rx_cnt_q + 6'h01;
    end
  end

  // receive bytes written one cycle after the field completes
  logic rx_store_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_store_q <= 1'b0;
    end else begin
      rx_store_q <= rx_done;
    end
  end

  // stored exactly as seen, srr/ide/rtr included
  always_ff @(posedge pclk) begin
    if (rx_store_q) begin
      if (rx_std_q) begin
        rxid_q[0] <= rx_sh_q[12:5];
        rxid_q[1][7:3] <= rx_sh_q[4:0];
      end else begin
        rxid_q[0] <= rx_sh_q[31:24];
        rxid_q[1] <= rx_sh_q[23:16];
        rxid_q[2] <= rx_sh_q[15:8];
        rxid_q[3] <= rx_sh_q[7:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign can_tx = can_tx_q;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_go_std;
    tx_start && !txid_q[1][`CMB_B1_IDE];
  endsequence

  sequence s_go_ext;
    tx_start && txid_q[1][`CMB_B1_IDE];
  endsequence

  AST_STD_LEN: assert property (s_go_std |=> tx_len_q == `CMB_STD_BITS)
    else $error("standard field length not 13");
  AST_EXT_LEN: assert property (s_go_ext |=> tx_len_q == `CMB_EXT_BITS)
    else $error("extended field length not 32");
  AST_FIRST_BIT: assert property ((tx_state_q == cmb_pkg::TX_SHIFT) && tick_q
      && tx_cnt_q == 6'h00 |=> can_tx_q == $past(txid_q[0][7]))
    else $error("first sent bit is not the identifier msb");
  AST_ARB_LOSS: assert property ((tx_state_q == cmb_pkg::TX_SHIFT) && tick_q
      && tx_cnt_q != 6'h00 && can_tx_q && !can_rx
      |=> arb_lost_q && transmit_buffer_empty_flag_q && can_tx_q)
    else $error("dominant readback did not end transmission");
  AST_EXT_STORE: assert property (rx_store_q && !rx_std_q
      |=> rxid_q[1] == $past(rx_sh_q[23:16]) && rxid_q[3][0] == $past(rx_sh_q[0]))
    else $error("extended receive bytes stored wrongly");
  AST_STD_STORE: assert property (rx_store_q && rx_std_q
      |=> rxid_q[0] == $past(rx_sh_q[12:5]) && rxid_q[1][3] == 1'b0)
    else $error("standard receive bytes stored wrongly");
  AST_RXF_SET: assert property (rx_done |=> receive_buffer_full_flag_q)
    else $error("receive full not set after field");
  AST_TX_LOCK: assert property (!transmit_buffer_empty_flag_q
      |=> $stable(txid_q[1]) && $stable(txid_q[0]))
    else $error("transmit bytes changed while pending");
  AST_IDLE_RECESSIVE: assert property (tx_state_q == cmb_pkg::TX_IDLE
      ##1 tx_state_q == cmb_pkg::TX_IDLE |-> can_tx_q)
    else $error("bus driven dominant while idle");
  AST_APB_ANSWER: assert property (psel && penable && !pready_q
      |=> pready_q ##1 !pready_q)
    else $error("apb answer not one wait state");

endmodule : cmb_idmap

// ==== tb/cmb_bus_node.sv ====
// other node on the can bus, wired-and with the device under test
// assumes a bit time of DIV pclk cycles and a recessive idle level of 1
module cmb_bus_node #(
  parameter int DIV = 4
) (
  // clock
  input wire logic pclk,
  // can wires
  input wire logic can_tx,
  output logic can_rx,
  output logic rx_frame
);
  timeunit 1ns;
  timeprecision 100ps;

  logic drv_q = 1'b1;
  logic frm_q = 1'b0;

  // dominant 0 wins; a released bus returns to recessive
  assign can_rx = can_tx & drv_q;
  assign rx_frame = frm_q;

  // frame head, msb first, one bit per bit time
  task automatic send(input logic [31:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      frm_q <= 1'b1;
      drv_q <= bits[31 - i];
      repeat (DIV) @(posedge pclk);
    end
    frm_q <= 1'b0;
    drv_q <= 1'b1;
  endtask : send

  // dominant hold, as a rival whose identifier is smaller
  task automatic jam(input int n);
    drv_q <= 1'b0;
    repeat (n) @(posedge pclk);
    drv_q <= 1'b1;
  endtask : jam
endmodule : cmb_bus_node

// ==== tb/tb.sv ====
// self-checking bench: apb master plus one other can node
// assumes cmb_defs.svh on the include path and BIT_DIV of 4
`include "cmb_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int DIV = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic can_rx;
  logic rx_frame;
  logic can_tx;
  logic [31:0] rd;
  logic er;
  int n_errors = 0;
  int n_tests = 0;

  // 250 MHz
  always #2 pclk = ~pclk;

  cmb_idmap #(.BIT_DIV(DIV)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .can_rx(can_rx), .rx_frame(rx_frame),
    .can_tx(can_tx));

  cmb_bus_node #(.DIV(DIV)) node (.pclk(pclk), .can_tx(can_tx), .can_rx(can_rx),
    .rx_frame(rx_frame));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    if (n_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // masked compare; an unknown inside the mask never matches
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input logic [31:0] m, input string what);
    n_tests++;
    if ((got & m) !== (exp & m)) begin
      n_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  // one apb transfer, request held until pready is seen high
  task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    logic late;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {26'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    late = (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (late) begin
      n_errors++;
      $display("BAD %0t apb timeout", $time);
      tally_and_finish();
    end
  endtask : apb

  // identifier bytes as software lays them out, b0 in the top byte
  function automatic logic [31:0] pack(input logic ext, input logic [28:0] id,
                                       input logic srr, input logic rtr);
    if (ext) begin
      return {id[28:18], srr, 1'b1, id[17:0], rtr};
    end
    return {id[10:0], rtr, 1'b0, 19'h0};
  endfunction : pack

  // fill the transmit bytes and read each one back
  task automatic load(input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `CMB_OFS_TXID0 + 6'(4 * i), {24'h0, v[31 - 8 * i -: 8]});
      apb(1'b0, `CMB_OFS_TXID0 + 6'(4 * i), 32'h0);
      check(rd, {24'h0, v[31 - 8 * i -: 8]}, 32'hFFFFFFFF, "tx byte");
    end
  endtask : load

  // start a frame; first bit must be dominant so the bit grid can be found
  task automatic tx_frame(input logic [31:0] v, input int n);
    int k;
    k = 0;
    load(v);
    apb(1'b1, `CMB_OFS_CTRL, 32'h11);
    while (can_tx !== 1'b0 && k < 8 * DIV) begin
      @(posedge pclk);
      k++;
    end
    if (can_tx !== 1'b0) begin
      n_errors++;
      $display("BAD %0t tx start timeout", $time);
      tally_and_finish();
    end
    @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      check({31'h0, can_tx}, {31'h0, v[31 - i]}, 32'h1, "tx bit");
      repeat (DIV) @(posedge pclk);
    end
    check({31'h0, can_tx}, 32'h1, 32'h1, "tx idle");
    apb(1'b0, `CMB_OFS_CTRL, 32'h0);
    check(rd, 32'h11, 32'h17, "tx done");
  endtask : tx_frame

  // receive a head and read it back; m hides bits left undefined
  task automatic rx_frame_chk(input logic [31:0] v, input int n, input logic [31:0] m);
    node.send(v, n);
    repeat (4) @(posedge pclk);
    apb(1'b0, `CMB_OFS_CTRL, 32'h0);
    check(rd, 32'h03, 32'h07, "rx full");
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, `CMB_OFS_RXID0 + 6'(4 * i), 32'h0);
      check(rd, {24'h0, v[31 - 8 * i -: 8]}, {24'hFFFFFF, m[31 - 8 * i -: 8]}, "rx byte");
    end
    apb(1'b1, `CMB_OFS_CTRL, 32'h02);
  endtask : rx_frame_chk

  // main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `CMB_OFS_CTRL, 32'h0);
    check(rd, 32'h01, 32'h17, "ctrl reset");
    apb(1'b0, 6'h24, 32'h0);
    check({31'h0, er}, 32'h1, 32'h1, "unmapped");
    // a write while the buffer is not selected is dropped
    apb(1'b1, `CMB_OFS_CTRL, 32'h10);
    apb(1'b1, `CMB_OFS_TXID0, 32'h5A);
    apb(1'b1, `CMB_OFS_CTRL, 32'h00);
    apb(1'b1, `CMB_OFS_TXID0, 32'hA5);
    apb(1'b1, `CMB_OFS_CTRL, 32'h10);
    apb(1'b0, `CMB_OFS_TXID0, 32'h0);
    check(rd, 32'h5A, 32'hFFFFFFFF, "unselected write");
    tx_frame(pack(1'b1, 29'h0ABCDE12, 1'b1, 1'b1), 32);
    tx_frame(pack(1'b0, 29'h123, 1'b0, 1'b0), 13);
    // rival drives dominant while our first bit is recessive
    load(pack(1'b1, 29'h1ABCDEF0, 1'b1, 1'b0));
    apb(1'b1, `CMB_OFS_CTRL, 32'h11);
    node.jam(4 * DIV);
    check({31'h0, can_tx}, 32'h1, 32'h1, "lost idle");
    apb(1'b0, `CMB_OFS_CTRL, 32'h0);
    check(rd, 32'h15, 32'h17, "arb lost");
    apb(1'b1, `CMB_OFS_CTRL, 32'h14);
    apb(1'b0, `CMB_OFS_CTRL, 32'h0);
    check(rd, 32'h11, 32'h17, "arb clear");
    rx_frame_chk(pack(1'b1, 29'h0ABCDE12, 1'b0, 1'b1), 32, 32'hFFFFFFFF);
    rx_frame_chk(pack(1'b0, 29'h5A3, 1'b0, 1'b1), 13, 32'hFFF80000);
    rx_frame_chk(pack(1'b1, 29'h1FFFFFFF, 1'b1, 1'b0), 32, 32'hFFFFFFFF);
    tally_and_finish();
  end
endmodule : tb
